// ---- common/usb_ep_flags_regs.vh ----
// Register map, field positions and reset values of the endpoint event flag block
// Function
// - Descriptor-done is set once the programmed descriptor length has been sent to the host.
// - An OUT token before all descriptor bytes are sent sets both descriptor-done and receive-NAK.
// - The short-packet flag is set in the same cycle as the receive-ACK flag for an acked short OUT packet.
// - The transmit-ACK flag is set when the host ACKs the endpoint's IN data packet.
// - The receive-ACK flag is set when the device ACKs an OUT transaction on the endpoint.
// - The transmit-NAK flag is set when the device NAKs an IN token on the endpoint.
// - The receive-NAK flag is set when the device NAKs an OUT or PING transaction on the endpoint.
// - The transmit-error flag is set on STALL, packet error or handshake timeout in an IN transaction.
// - The receive-error flag is set on STALL or packet error in an OUT transaction.
// - A flag stays set until software writes 1 to it; writing 0 leaves it alone.
// - A flag reaches the interrupt request only through its enable bit, the latched status and the mask.
// - Endpoints a, b and c have their own 8-bit flag registers at consecutive addresses, bit 7 reserved.
// - The control endpoint register sits just below endpoint a, with descriptor-done in bit 7.
// - An endpoint's summary bit reads 1 while any of its flags is set together with its enable bit.
`ifndef USB_EP_FLAGS_REGS_VH
`define USB_EP_FLAGS_REGS_VH

// Register indices; byte address is four times the index
`define IDX_CTRL_FLAGS     8'hB5
`define IDX_EPA_FLAGS      8'hB6
`define IDX_EPB_FLAGS      8'hB7
`define IDX_EPC_FLAGS      8'hB8
`define IDX_CTRL_ENABLE    8'hC0
`define IDX_EPA_ENABLE     8'hC1
`define IDX_EPB_ENABLE     8'hC2
`define IDX_EPC_ENABLE     8'hC3
`define IDX_SUMMARY        8'hC4
`define IDX_IRQ_STATUS     8'hC5
`define IDX_IRQ_MASK       8'hC6
`define IDX_DESC_LENGTH    8'hC7

// Flag bit positions
`define BIT_DESC_DONE      7
`define BIT_RX_SHORT_ACK   6
`define BIT_TX_ACK         5
`define BIT_RX_ACK         4
`define BIT_TX_NAK         3
`define BIT_RX_NAK         2
`define BIT_TX_ERR         1
`define BIT_RX_ERR         0

// Implemented flag bits per register kind
`define CTRL_FLAG_BITS     8'hFF
`define GEN_FLAG_BITS      8'h7F

// Reset values
`define RST_FLAGS          8'h00
`define RST_ENABLE         8'h00
`define RST_IRQ_MASK       4'h0
`define RST_DESC_LENGTH    16'h0000

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ---- design/desc_reply_tracker.v ----
// Byte counter for descriptor reply on the control endpoint
`timescale 1ns/1ps
module desc_reply_tracker #(
  parameter LEN_W = 16
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             sys_rst,
  // Descriptor reply progress
  input  wire             desc_start,
  input  wire [LEN_W-1:0] desc_length,
  input  wire             desc_byte_sent,
  input  wire             ctrl_out_token,
  // Outcomes: done and early one-cycle pulses, busy level
  output wire             desc_done_set,
  output wire             desc_early_set,
  output reg              desc_busy
);

  reg  [LEN_W-1:0] sent_count;
  wire [LEN_W-1:0] next_count;
  wire             reach_end;

  assign next_count = sent_count + {{(LEN_W-1){1'b0}}, 1'b1};
  assign reach_end = desc_busy & desc_byte_sent & (next_count >= desc_length);
  assign desc_early_set = desc_busy & ctrl_out_token & ~reach_end;
  assign desc_done_set = reach_end | desc_early_set;

  // Count bytes while a reply runs
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      desc_busy  <= 1'b0;
      sent_count <= {LEN_W{1'b0}};
    end else if (desc_start) begin
      desc_busy  <= 1'b1;
      sent_count <= {LEN_W{1'b0}};
    end else if (desc_done_set) begin
      desc_busy  <= 1'b0;
    end else if (desc_busy && desc_byte_sent) begin
      sent_count <= next_count;
    end
  end

endmodule

// ---- design/ep_flag_reg.v ----
// One endpoint's sticky write-1-to-clear event flag register
`timescale 1ns/1ps
module ep_flag_reg #(
  parameter [7:0] IMPL_BITS = 8'hFF
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  // Hardware set and software clear
  input  wire [7:0] set_bits,
  input  wire [7:0] clr_bits,
  // Flag state
  output reg  [7:0] flags
);

  // Sticky flags; set wins over clear, reserved bits stay zero
  // write-1 clear
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= 8'h00;
    end else begin
      flags <= ((flags & ~clr_bits) | set_bits) & IMPL_BITS;
    end
  end

endmodule

// ---- design/usb_endpoint_event_flags.v ----
// Endpoint event flags of the device controller with AXI4-Lite register access
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "usb_ep_flags_regs.vh"
module usb_endpoint_event_flags #(
  parameter ADDR_W = 12,
  parameter LEN_W  = 16
) (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              sys_rst,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Transaction events, bit 0 control endpoint, bits 1..3 endpoints a..c
  input  wire [3:0]        ev_in_acked,
  input  wire [3:0]        ev_out_acked,
  input  wire [3:0]        ev_out_short,
  input  wire [3:0]        ev_in_nakked,
  input  wire [3:0]        ev_out_nakked,
  input  wire [3:0]        ev_ping_nakked,
  input  wire [3:0]        ev_in_stall,
  input  wire [3:0]        ev_in_pkt_err,
  input  wire [3:0]        ev_in_timeout,
  input  wire [3:0]        ev_out_stall,
  input  wire [3:0]        ev_out_pkt_err,
  // Descriptor reply on the control endpoint
  input  wire              desc_start,
  input  wire              desc_byte_sent,
  input  wire              ctrl_out_token,
  output wire              desc_busy,
  // Interrupt and summary
  output wire [3:0]        endpoint_summary_flags,
  output wire              irq
);

  // Write channel holding registers
  reg  [ADDR_W-1:0] aw_addr;
  reg               aw_held;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;
  reg               w_held;
  wire              wr_fire;
  wire [7:0]        wr_idx;
  wire [7:0]        rd_idx;
  wire              rd_fire;

  // Software state
  reg  [7:0]        ep_enable [0:3];
  reg  [3:0]        irq_status;
  reg  [3:0]        irq_mask;
  reg  [LEN_W-1:0]  descriptor_length_setting;

  // Flag state and per-endpoint set and clear vectors
  wire [7:0]        flags    [0:3];
  wire [7:0]        set_vec  [0:3];
  wire [7:0]        clr_vec  [0:3];
  wire              desc_done_set;
  wire              desc_early_set;
  reg  [31:0]       next_rdata;
  reg               next_rerr;

  // Address decode results
  wire              wr_page_ok;
  wire              rd_page_ok;
  wire              wr_flag_hit;
  wire              wr_own_hit;
  wire              wr_map_ok;

  // Register indices from byte addresses
  assign wr_idx = aw_addr[9:2];
  assign rd_idx = s_axi_araddr[9:2];

  // Low page and word aligned, else refused
  assign wr_page_ok  = (aw_addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) && (aw_addr[1:0] == 2'h0);
  assign rd_page_ok  = (s_axi_araddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) && (s_axi_araddr[1:0] == 2'h0);
  // Flag words and own control words
  assign wr_flag_hit = (wr_idx >= `IDX_CTRL_FLAGS) && (wr_idx <= `IDX_EPC_FLAGS);
  assign wr_own_hit  = (wr_idx >= `IDX_CTRL_ENABLE) && (wr_idx <= `IDX_DESC_LENGTH);
  assign wr_map_ok   = wr_page_ok && (wr_flag_hit || wr_own_hit);

  // Address and data accepted independently
  // One slot per channel; a full slot refuses the next offer
  // Write fires only once the previous response is taken
  // Read address refused while a result waits
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;

  // Capture write address and data
  // Either channel may arrive first; each waits in its slot
  // Slots empty on the cycle the write is applied
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // Both slots empty after reset
      aw_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      // Address slot
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      // Data slot
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  // Raised one cycle after both halves are held
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // No response pending after reset
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      // Refused words answer with an error and change nothing
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      // Response held until the master takes it
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software registers: enables, mask, descriptor length
  // Misaligned or off-page writes are dropped
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // Everything off after reset
      ep_enable[0]              <= `RST_ENABLE;
      ep_enable[1]              <= `RST_ENABLE;
      ep_enable[2]              <= `RST_ENABLE;
      ep_enable[3]              <= `RST_ENABLE;
      irq_mask                  <= `RST_IRQ_MASK;
      descriptor_length_setting <= `RST_DESC_LENGTH;
    end else if (wr_fire && wr_page_ok) begin
      // Control endpoint enables, all eight bits
      if (w_strb[0] && wr_idx == `IDX_CTRL_ENABLE) begin
        ep_enable[0] <= w_data[7:0];
      end
      // General endpoint enables, bit 7 kept clear
      if (w_strb[0] && wr_idx == `IDX_EPA_ENABLE) begin
        ep_enable[1] <= w_data[7:0] & `GEN_FLAG_BITS;
      end
      if (w_strb[0] && wr_idx == `IDX_EPB_ENABLE) begin
        ep_enable[2] <= w_data[7:0] & `GEN_FLAG_BITS;
      end
      if (w_strb[0] && wr_idx == `IDX_EPC_ENABLE) begin
        ep_enable[3] <= w_data[7:0] & `GEN_FLAG_BITS;
      end
      // Interrupt mask, one bit per endpoint
      if (w_strb[0] && wr_idx == `IDX_IRQ_MASK) begin
        irq_mask <= w_data[3:0];
      end
      // Descriptor length, two byte lanes
      if (wr_idx == `IDX_DESC_LENGTH) begin
        if (w_strb[0]) begin
          descriptor_length_setting[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          descriptor_length_setting[LEN_W-1:8] <= w_data[LEN_W-1:8];
        end
      end
    end
  end

  // Descriptor reply byte tracking
  // Counts bytes of a reply and reports its end
  desc_reply_tracker #(
    .LEN_W (LEN_W)
  ) u_desc (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .desc_start     (desc_start),
    .desc_length    (descriptor_length_setting),
    .desc_byte_sent (desc_byte_sent),
    .ctrl_out_token (ctrl_out_token),
    .desc_done_set  (desc_done_set),
    .desc_early_set (desc_early_set),
    .desc_busy      (desc_busy)
  );

  // Per-endpoint flag registers and their set and clear terms
  // Control endpoint is entry 0, endpoints a to c follow
  genvar ep;
  generate
    for (ep = 0; ep < 4; ep = ep + 1) begin : g_ep
      assign set_vec[ep][`BIT_DESC_DONE]    = (ep == 0) ? desc_done_set : 1'b0;

      // Short flag only rides on an ACK
      // short ack with receive ack
      assign set_vec[ep][`BIT_RX_SHORT_ACK] = ev_out_acked[ep] & ev_out_short[ep];

      assign set_vec[ep][`BIT_TX_ACK]       = ev_in_acked[ep];

      assign set_vec[ep][`BIT_RX_ACK]       = ev_out_acked[ep];

      assign set_vec[ep][`BIT_TX_NAK]       = ev_in_nakked[ep];

      // Early status stage counts as a receive NAK
      // OUT or PING nakked
      assign set_vec[ep][`BIT_RX_NAK]       = ev_out_nakked[ep] | ev_ping_nakked[ep] |
                                              ((ep == 0) ? desc_early_set : 1'b0);

      assign set_vec[ep][`BIT_TX_ERR]       = ev_in_stall[ep] | ev_in_pkt_err[ep] | ev_in_timeout[ep];

      assign set_vec[ep][`BIT_RX_ERR]       = ev_out_stall[ep] | ev_out_pkt_err[ep];

      // write 1 clears the bit
      // Only this endpoint's word, low byte lane
      assign clr_vec[ep] = (wr_fire && w_strb[0] && wr_page_ok && wr_idx == `IDX_CTRL_FLAGS + ep) ?
                           w_data[7:0] : 8'h00;

      // Reserved bit 7 of a to c forced clear inside
      // own register per general endpoint
      ep_flag_reg #(
        .IMPL_BITS ((ep == 0) ? `CTRL_FLAG_BITS : `GEN_FLAG_BITS)
      ) u_flags (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .set_bits (set_vec[ep]),
        .clr_bits (clr_vec[ep]),
        .flags    (flags[ep])
      );

      // Summary bit per endpoint, combinational
      // enabled flag shows in summary
      assign endpoint_summary_flags[ep] = |(flags[ep] & ep_enable[ep]);
    end
  endgenerate

  // Sticky interrupt status, cleared by reading it; set wins
  // A status bit latches any summary bit that was high
  // masked status, not the raw flags, drives the request
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_status <= 4'h0;
    end else if (rd_fire && rd_page_ok && rd_idx == `IDX_IRQ_STATUS) begin
      // Read clears, but a bit still pending sets again at once
      irq_status <= endpoint_summary_flags;
    end else begin
      // Otherwise accumulate pending bits
      irq_status <= irq_status | endpoint_summary_flags;
    end
  end

  // Level interrupt output
  // Masked bits never reach the pin
  assign irq = |(irq_status & irq_mask);

  // Read data selection
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    // Refused words read as zero with an error
    if (!rd_page_ok) begin
      next_rerr = 1'b1;
    end else begin
      // Upper bits of every word read zero
      case (rd_idx)
        `IDX_CTRL_FLAGS:  next_rdata[7:0] = flags[0];
        `IDX_EPA_FLAGS:   next_rdata[7:0] = flags[1];
        `IDX_EPB_FLAGS:   next_rdata[7:0] = flags[2];
        `IDX_EPC_FLAGS:   next_rdata[7:0] = flags[3];
        `IDX_CTRL_ENABLE: next_rdata[7:0] = ep_enable[0];
        `IDX_EPA_ENABLE:  next_rdata[7:0] = ep_enable[1];
        `IDX_EPB_ENABLE:  next_rdata[7:0] = ep_enable[2];
        `IDX_EPC_ENABLE:  next_rdata[7:0] = ep_enable[3];
        `IDX_SUMMARY:     next_rdata[3:0] = endpoint_summary_flags;
        `IDX_IRQ_STATUS:  next_rdata[3:0] = irq_status;
        `IDX_IRQ_MASK:    next_rdata[3:0] = irq_mask;
        `IDX_DESC_LENGTH: next_rdata[LEN_W-1:0] = descriptor_length_setting;
        // Holes in the map answer with an error
        default:          next_rerr = 1'b1;
      endcase
    end
  end

  // Read response
  // Data captured at the address edge, held until taken
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- verif/usb_endpoint_event_flags_tb_top.sv ----
// Testbench of the endpoint event flag block
`timescale 1ns/1ps
`include "usb_ep_flags_regs.vh"
module usb_endpoint_event_flags_tb_top;
  reg         sys_clk = 1'b0, sys_rst = 1'b1, go = 1'b0;
  reg  [1:0]  ep = 2'h0, resp;
  reg  [3:0]  kind = 4'h0;
  reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg  [31:0] wdata = 32'h0, rd;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, got;
  wire        awready, wready, bvalid, arready, rvalid, d_st, d_by, d_out, desc_busy, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  ia, oa, os, in_n, on, pn, ist, ipe, ito, ost, ope, summary;
  integer     fails = 0, n_checks = 0, i, k;
  // Clock
  always #50 sys_clk = ~sys_clk;
  usb_endpoint_event_flags u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ev_in_acked(ia), .ev_out_acked(oa), .ev_out_short(os), .ev_in_nakked(in_n), .ev_out_nakked(on),
    .ev_ping_nakked(pn), .ev_in_stall(ist), .ev_in_pkt_err(ipe), .ev_in_timeout(ito), .ev_out_stall(ost),
    .ev_out_pkt_err(ope), .desc_start(d_st), .desc_byte_sent(d_by), .ctrl_out_token(d_out),
    .desc_busy(desc_busy), .endpoint_summary_flags(summary), .irq(irq));
  usb_link_model u_link (.go(go), .ep(ep), .kind(kind), .ev_in_acked(ia), .ev_out_acked(oa),
    .ev_out_short(os), .ev_in_nakked(in_n), .ev_out_nakked(on), .ev_ping_nakked(pn), .ev_in_stall(ist),
    .ev_in_pkt_err(ipe), .ev_in_timeout(ito), .ev_out_stall(ost), .ev_out_pkt_err(ope),
    .desc_start(d_st), .desc_byte_sent(d_by), .ctrl_out_token(d_out));
  function [11:0] ra(input [7:0] idx);
    ra = {2'b00, idx, 2'b00};
  endfunction
  // Flag bits expected from each event kind
  function [31:0] exp_bits(input integer kd);
    case (kd)
      0: exp_bits = 32'h20;
      1: exp_bits = 32'h10;
      2: exp_bits = 32'h50;
      3: exp_bits = 32'h08;
      4, 5: exp_bits = 32'h04;
      6, 7, 8: exp_bits = 32'h02;
      default: exp_bits = 32'h01;
    endcase
  endfunction
  task stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string name, input [31:0] exp, input [31:0] seen);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin resp = bresp; bready <= 1'b0; got = 1'b1; end
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin rd = rdata; resp = rresp; rready <= 1'b0; got = 1'b1; end
    end
    chk("rdata", exp, rd);
  endtask
  task ev(input [1:0] e, input [3:0] kd);
    @(posedge sys_clk);
    ep <= e; kind <= kd; go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask
  // Watchdog
  initial begin
    #(100 * 6000);
    fails = fails + 1;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1) rdc(ra(`IDX_CTRL_FLAGS + i), 32'h0);
    rdc(ra(8'hB9), 32'h0);
    chk("rresp", `RESP_SLVERR, resp);
    wr(ra(8'hB9), 32'hFF);
    chk("bresp", `RESP_SLVERR, resp);
    wr(ra(`IDX_EPA_ENABLE) | 12'h1, 32'hFF);
    chk("bresp", `RESP_SLVERR, resp);
    rdc(ra(`IDX_EPA_ENABLE), 32'h0);
    // Event kinds 0 to 10 on every endpoint, then write 0 and write 1
    for (i = 0; i < 4; i = i + 1) for (k = 0; k < 11; k = k + 1) begin
      ev(i, k);
      rdc(ra(`IDX_CTRL_FLAGS + i), exp_bits(k));
      wr(ra(`IDX_CTRL_FLAGS + i), ~exp_bits(k));
      rdc(ra(`IDX_CTRL_FLAGS + i), exp_bits(k));
      wr(ra(`IDX_CTRL_FLAGS + i), exp_bits(k));
      rdc(ra(`IDX_CTRL_FLAGS + i), 32'h0);
    end
    // Event lands in the cycle of the clearing write
    ev(1, 0);
    fork
      wr(ra(`IDX_EPA_FLAGS), 32'h20);
      begin @(posedge sys_clk); @(posedge sys_clk); ep <= 2'h1; kind <= 4'h0; go <= 1'b1;
        @(posedge sys_clk); go <= 1'b0; end
    join
    rdc(ra(`IDX_EPA_FLAGS), 32'h20);
    wr(ra(`IDX_EPA_FLAGS) | 12'h2, 32'h20);
    rdc(ra(`IDX_EPA_FLAGS), 32'h20);
    wr(ra(`IDX_EPA_FLAGS), 32'h20);
    // Descriptor reply of three bytes
    wr(ra(`IDX_DESC_LENGTH), 32'h3);
    ev(0, 11); ev(0, 12); ev(0, 12);
    rdc(ra(`IDX_CTRL_FLAGS), 32'h0);
    ev(0, 12);
    rdc(ra(`IDX_CTRL_FLAGS), 32'h80);
    chk("desc_busy", 32'h0, {31'h0, desc_busy});
    wr(ra(`IDX_CTRL_FLAGS), 32'hFF);
    // Status stage before all bytes
    ev(0, 11); ev(0, 12); ev(0, 13);
    rdc(ra(`IDX_CTRL_FLAGS), 32'h84);
    wr(ra(`IDX_CTRL_FLAGS), 32'hFF);
    // Interrupt raised, masked and cleared
    wr(ra(`IDX_EPA_ENABLE), 32'hFF);
    rdc(ra(`IDX_EPA_ENABLE), 32'h7F);
    wr(ra(`IDX_IRQ_MASK), 32'h2);
    ev(1, 3);
    #1 chk("summary", 32'h2, {28'h0, summary});
    @(posedge sys_clk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wr(ra(`IDX_IRQ_MASK), 32'h0);
    #1 chk("irq", 32'h0, {31'h0, irq});
    wr(ra(`IDX_IRQ_MASK), 32'h2);
    wr(ra(`IDX_EPA_FLAGS), 32'h08);
    #1 chk("summary", 32'h0, {28'h0, summary});
    rdc(ra(`IDX_IRQ_STATUS), 32'h2);
    #1 chk("irq", 32'h0, {31'h0, irq});
    stop_test;
  end
endmodule

// ---- verif/usb_ep_flags_props.sv ----
// Assertions on the ports of the endpoint event flag block
`timescale 1ns/1ps
module usb_ep_flags_props (
  // Clock and reset
  input wire        sys_clk,
  input wire        sys_rst,
  // Bus handshakes
  input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Transaction events
  input wire [3:0]  ev_in_acked, ev_out_acked, ev_out_short, ev_in_nakked, ev_out_nakked, ev_ping_nakked,
  input wire [3:0]  ev_in_stall, ev_in_pkt_err, ev_in_timeout, ev_out_stall, ev_out_pkt_err,
  // Descriptor reply and outputs
  input wire        desc_start, desc_byte_sent, ctrl_out_token, desc_busy, irq,
  input wire [3:0]  endpoint_summary_flags
);
  // Any event that may set a flag
  wire ev_any = |{ev_in_acked, ev_out_acked, ev_in_nakked, ev_out_nakked, ev_ping_nakked, ev_in_stall,
                  ev_in_pkt_err, ev_in_timeout, ev_out_stall, ev_out_pkt_err, desc_byte_sent, ctrl_out_token};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_reset_quiet;
    $fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !desc_busy && endpoint_summary_flags == 4'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data not held");
  property p_summary_cause;
    !$stable(endpoint_summary_flags) && !$past(sys_rst) |-> $past(ev_any) || $rose(s_axi_bvalid);
  endproperty
  a_summary_cause: assert property (p_summary_cause) else $error("summary moved without cause");
  property p_flags_sticky;
    |($past(endpoint_summary_flags) & ~endpoint_summary_flags) |-> $rose(s_axi_bvalid);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("summary fell without write");
  property p_irq_cause;
    $rose(irq) && !$past(sys_rst) |-> $past(|endpoint_summary_flags) || $rose(s_axi_bvalid);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_desc_begin;
    desc_start && !desc_byte_sent && !ctrl_out_token |=> desc_busy [*2];
  endproperty
  a_desc_begin: assert property (p_desc_begin) else $error("reply did not start");
  property p_desc_end;
    $fell(desc_busy) && !$past(sys_rst) |-> $past(desc_byte_sent || ctrl_out_token);
  endproperty
  a_desc_end: assert property (p_desc_end) else $error("reply ended without cause");
  c_desc: cover property (desc_start ##[1:20] $fell(desc_busy));
  c_irq: cover property ($rose(irq));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind usb_endpoint_event_flags usb_ep_flags_props u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .ev_in_acked(ev_in_acked),
  .ev_out_acked(ev_out_acked), .ev_out_short(ev_out_short), .ev_in_nakked(ev_in_nakked),
  .ev_out_nakked(ev_out_nakked), .ev_ping_nakked(ev_ping_nakked), .ev_in_stall(ev_in_stall),
  .ev_in_pkt_err(ev_in_pkt_err), .ev_in_timeout(ev_in_timeout), .ev_out_stall(ev_out_stall),
  .ev_out_pkt_err(ev_out_pkt_err), .desc_start(desc_start), .desc_byte_sent(desc_byte_sent),
  .ctrl_out_token(ctrl_out_token), .desc_busy(desc_busy), .irq(irq),
  .endpoint_summary_flags(endpoint_summary_flags));

// ---- verif/usb_link_model.sv ----
// Link side model turning bench commands into one-cycle transaction events
`timescale 1ns/1ps
module usb_link_model (
  // Command
  input  wire       go,
  input  wire [1:0] ep,
  input  wire [3:0] kind,
  // Transaction events
  output wire [3:0] ev_in_acked, ev_out_acked, ev_out_short, ev_in_nakked, ev_out_nakked, ev_ping_nakked,
  output wire [3:0] ev_in_stall, ev_in_pkt_err, ev_in_timeout, ev_out_stall, ev_out_pkt_err,
  // Descriptor reply progress
  output wire       desc_start, desc_byte_sent, ctrl_out_token
);
  // Endpoint select, idle when no command
  wire [3:0] sel = go ? (4'h1 << ep) : 4'h0;
  assign ev_in_acked = (kind == 4'h0) ? sel : 4'h0;
  assign ev_out_acked = (kind == 4'h1 || kind == 4'h2) ? sel : 4'h0;
  assign ev_out_short = (kind == 4'h2) ? sel : 4'h0;
  assign ev_in_nakked = (kind == 4'h3) ? sel : 4'h0;
  assign ev_out_nakked = (kind == 4'h4) ? sel : 4'h0;
  assign ev_ping_nakked = (kind == 4'h5) ? sel : 4'h0;
  assign ev_in_stall = (kind == 4'h6) ? sel : 4'h0;
  assign ev_in_pkt_err = (kind == 4'h7) ? sel : 4'h0;
  assign ev_in_timeout = (kind == 4'h8) ? sel : 4'h0;
  assign ev_out_stall = (kind == 4'h9) ? sel : 4'h0;
  assign ev_out_pkt_err = (kind == 4'hA) ? sel : 4'h0;
  assign desc_start = go && kind == 4'hB;
  assign desc_byte_sent = go && kind == 4'hC;
  assign ctrl_out_token = go && kind == 4'hD;
endmodule
